// [hdl/apcg_top.sv]
// slow peripheral bus clock gate register with wishbone access
// Overview of operation
// - gate register at offset 0x1c, resets to zero, all clocks off.
// - bit 29 enables the dac clock, read/write.
// - bit 28 enables the power management unit clock, read/write.
// - bit 27 enables the backup interface clock, read/write.
// - bits 22 and 21 enable the i2c 1 and i2c 0 clocks.
// - bits 20 and 19 enable the uart 4 and uart 3 clocks.
// - bits 18 and 17 enable the usart 2 and usart 1 clocks.
// - bits 15 and 14 enable the spi 2 and spi 1 clocks.
// - bit 11 enables the window watchdog clock, read/write.
// - bits 8, 7, 6 enable timers 13, 12, 11.
// - bits 5 down to 0 enable timers 6 down to 1.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module apcg_top
#(
    parameter int unsigned ADDR_WIDTH = 8
)
(
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // wishbone classic slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [ADDR_WIDTH-1:0] wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // peripheral clock enables
    output logic                       dacClockGate,
    output logic                       powerUnitClockGate,
    output logic                       backupIfClockGate,
    output logic                       i2cPort1ClockGate,
    output logic                       i2cPort0ClockGate,
    output logic                       uartPort4ClockGate,
    output logic                       uartPort3ClockGate,
    output logic                       usartPort2ClockGate,
    output logic                       usartPort1ClockGate,
    output logic                       spiPort2ClockGate,
    output logic                       spiPort1ClockGate,
    output logic                       windowWatchdogClockGate,
    output logic                       timer13ClockGate,
    output logic                       timer12ClockGate,
    output logic                       timer11ClockGate,
    output logic                       timer6ClockGate,
    output logic                       timer5ClockGate,
    output logic                       timer4ClockGate,
    output logic                       timer3ClockGate,
    output logic                       timer2ClockGate,
    output logic                       timer1ClockGate
);

    if (ADDR_WIDTH < 8)
    begin : gen_bad_width
        $error("apcg_top: ADDR_WIDTH must be at least 8");
    end

    logic [31:0]                        slowBusClockGatesReg;
    logic [31:0]                        slowBusClockGatesNext;
    logic [31:0]                        datReg;
    logic [31:0]                        datNext;
    logic                               ackWire;
    logic                               commitWrite;
    logic                               takeRead;
    logic [7:0]                         offset;
    logic                               upperZero;
    logic [apcg_pkg::GATE_COUNT-1:0]    gateVec;
    logic [31:0]                        gateStatus;

    // only the low byte decodes, upper address bits must be zero
    assign offset    = wb_adr_i[7:0];
    assign upperZero = (wb_adr_i >> 8) == '0;

    apcg_wb_ack u_ack
    (
        .mclk (mclk),
        .rst  (rst),
        .cyc  (wb_cyc_i),
        .stb  (wb_stb_i),
        .ack  (ackWire)
    );

    // a write takes effect at the edge where ack is seen high
    assign commitWrite = wb_cyc_i && wb_stb_i && wb_we_i && ackWire;
    assign takeRead    = wb_cyc_i && wb_stb_i && !wb_we_i && !ackWire;

    always_comb
    begin
        slowBusClockGatesNext = slowBusClockGatesReg;
        if (commitWrite && upperZero && offset == apcg_pkg::SLOW_BUS_CLOCK_GATES_OFFSET)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (wb_sel_i[b])
                begin
                    slowBusClockGatesNext[8*b +: 8] = wb_dat_i[8*b +: 8];
                end
            end
            slowBusClockGatesNext = slowBusClockGatesNext & apcg_pkg::WRITABLE_MASK;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            slowBusClockGatesReg <= apcg_pkg::SLOW_BUS_CLOCK_GATES_RESET;
        end
        else
        begin
            slowBusClockGatesReg <= slowBusClockGatesNext;
        end
    end

    // status shows the enables as the gates really see them
    always_comb
    begin
        gateStatus = '0;
        for (int g = 0; g < apcg_pkg::GATE_COUNT; g++)
        begin
            gateStatus[apcg_pkg::GATE_POS[g]] = gateVec[g];
        end
    end

    always_comb
    begin
        datNext = datReg;
        if (takeRead)
        begin
            if (upperZero && offset == apcg_pkg::SLOW_BUS_CLOCK_GATES_OFFSET)
            begin
                datNext = slowBusClockGatesReg;
            end
            else if (upperZero && offset == apcg_pkg::GATE_STATUS_OFFSET)
            begin
                datNext = gateStatus;
            end
            else
            begin
                datNext = apcg_pkg::UNMAPPED_READ_VALUE;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            datReg <= '0;
        end
        else
        begin
            datReg <= datNext;
        end
    end

    assign wb_dat_o = datReg;
    assign wb_ack_o = ackWire;

    for (genvar g = 0; g < apcg_pkg::GATE_COUNT; g++)
    begin : gen_gate
        apcg_gate_stage u_stage
        (
            .mclk       (mclk),
            .rst        (rst),
            .enableIn   (slowBusClockGatesReg[apcg_pkg::GATE_POS[g]]),
            .gateEnable (gateVec[g])
        );
    end

    assign dacClockGate            = gateVec[0];
    assign powerUnitClockGate      = gateVec[1];
    assign backupIfClockGate       = gateVec[2];
    assign i2cPort1ClockGate       = gateVec[3];
    assign i2cPort0ClockGate       = gateVec[4];
    assign uartPort4ClockGate      = gateVec[5];
    assign uartPort3ClockGate      = gateVec[6];
    assign usartPort2ClockGate     = gateVec[7];
    assign usartPort1ClockGate     = gateVec[8];
    assign spiPort2ClockGate       = gateVec[9];
    assign spiPort1ClockGate       = gateVec[10];
    assign windowWatchdogClockGate = gateVec[11];
    assign timer13ClockGate        = gateVec[12];
    assign timer12ClockGate        = gateVec[13];
    assign timer11ClockGate        = gateVec[14];
    assign timer6ClockGate         = gateVec[15];
    assign timer5ClockGate         = gateVec[16];
    assign timer4ClockGate         = gateVec[17];
    assign timer3ClockGate         = gateVec[18];
    assign timer2ClockGate         = gateVec[19];
    assign timer1ClockGate         = gateVec[20];

    // checks, sampled on the rising edge
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    logic gateWrite;
    assign gateWrite = commitWrite && upperZero
                       && offset == apcg_pkg::SLOW_BUS_CLOCK_GATES_OFFSET;

    chk_reset_clear: assert property (@(posedge mclk) disable iff (1'b0)
        rst |=> slowBusClockGatesReg == 32'h00000000 ##1 !dacClockGate && !timer1ClockGate)
        else $error("gate register not cleared by reset");

    chk_gates_reset: assert property (@(posedge mclk) disable iff (1'b0)
        rst |=> gateVec == '0)
        else $error("gate outputs not cleared by reset");

    chk_read_offset: assert property (
        takeRead && upperZero && offset == 8'h1c
        |=> wb_ack_o && wb_dat_o == $past(slowBusClockGatesReg))
        else $error("read of gate register returned wrong data");

    chk_unmapped_zero: assert property (
        takeRead && !(upperZero && (offset == 8'h1c || offset == 8'h3c))
        |=> wb_dat_o == 32'h00000000)
        else $error("unmapped read returned nonzero data");

    chk_other_write: assert property (
        commitWrite && !(upperZero && offset == 8'h1c)
        |=> $stable(slowBusClockGatesReg))
        else $error("write elsewhere changed the gate register");

    chk_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");

    chk_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in one cycle");

    chk_ack_idle: assert property (
        !wb_cyc_i |=> !wb_ack_o)
        else $error("acknowledge without a request");

    chk_dac_write: assert property (
        gateWrite && wb_sel_i[3]
        |=> slowBusClockGatesReg[29] == $past(wb_dat_i[29])
        ##1 dacClockGate == $past(wb_dat_i[29], 2))
        else $error("dac gate did not follow write");

    chk_power_rise: assert property (
        $rose(slowBusClockGatesReg[28]) |-> !powerUnitClockGate ##1 powerUnitClockGate)
        else $error("power unit gate did not turn on");

    // backup fall, reset clears the gates half a cycle ahead of the register
    chk_backup_fall: assert property (
        !$past(rst) && $fell(slowBusClockGatesReg[27])
        |-> backupIfClockGate ##1 !backupIfClockGate)
        else $error("backup interface gate did not turn off");

    chk_i2c_follow: assert property (
        !$past(rst) |-> {i2cPort1ClockGate, i2cPort0ClockGate}
        == $past(slowBusClockGatesReg[22:21]))
        else $error("i2c gates do not follow register");

    chk_uart_hold: assert property (
        !gateWrite |=> $stable(slowBusClockGatesReg[20:19])
        ##1 $stable({uartPort4ClockGate, uartPort3ClockGate}))
        else $error("uart enables changed without a write");

    chk_usart_write: assert property (
        gateWrite && wb_sel_i[2]
        |=> slowBusClockGatesReg[18:17] == $past(wb_dat_i[18:17]))
        else $error("usart enables not written");

    chk_spi_lane: assert property (
        gateWrite && !wb_sel_i[1] |=> $stable(slowBusClockGatesReg[15:14]))
        else $error("spi enables written with lane off");

    chk_watchdog_off: assert property (
        !slowBusClockGatesReg[11] [*2] |-> !windowWatchdogClockGate)
        else $error("watchdog gate on while bit clear");

    chk_watchdog_on: assert property (
        slowBusClockGatesReg[11] [*2] |-> windowWatchdogClockGate)
        else $error("watchdog gate off while bit set");

    chk_timer_high: assert property (
        !$past(rst) |-> {timer13ClockGate, timer12ClockGate, timer11ClockGate}
        == $past(slowBusClockGatesReg[8:6]))
        else $error("timer 13..11 gates do not follow register");

    chk_timer_low: assert property (
        gateWrite && wb_sel_i[0] |-> ##2
        {timer6ClockGate, timer5ClockGate, timer4ClockGate,
         timer3ClockGate, timer2ClockGate, timer1ClockGate} == $past(wb_dat_i[5:0], 2))
        else $error("timer 6..1 gates wrong after write");

    chk_low_lane: assert property (
        gateWrite && !wb_sel_i[0] |=> $stable(slowBusClockGatesReg[7:0]))
        else $error("low timer enables written with lane off");

    chk_reserved_zero: assert property (
        (slowBusClockGatesReg & ~32'h387ec9ff) == 32'h00000000)
        else $error("reserved bit set in gate register");

    chk_gate_latency: assert property (
        gateWrite |-> ##2 gateStatus == $past(slowBusClockGatesNext, 1))
        else $error("gate outputs late or wrong");

    chk_gate_quiet: assert property (
        $stable(slowBusClockGatesReg) [*2] |-> $stable(gateVec))
        else $error("gate output moved without cause");

    chk_status_read: assert property (
        takeRead && upperZero && offset == 8'h3c |=> wb_dat_o == $past(gateStatus))
        else $error("status read does not show the gate outputs");

    cov_enable_all: cover property (gateWrite && (wb_dat_i & 32'h387ec9ff) == 32'h387ec9ff
        && wb_sel_i == 4'hf);
    cov_status_read: cover property (takeRead && upperZero && offset == 8'h3c);
    cov_unmapped: cover property (takeRead && offset == 8'h20);
    cov_partial_lane: cover property (gateWrite && wb_sel_i == 4'h1);
    cov_gate_on: cover property ($rose(dacClockGate));

endmodule
`default_nettype wire

// [hdl/apcg_pkg.sv]
// constants for the slow peripheral bus clock gate register block
package apcg_pkg;

    // register map, byte offsets
    localparam logic [7:0]  SLOW_BUS_CLOCK_GATES_OFFSET = 8'h1c;
    localparam logic [7:0]  GATE_STATUS_OFFSET          = 8'h3c;
    localparam logic [31:0] SLOW_BUS_CLOCK_GATES_RESET  = 32'h00000000;
    localparam logic [31:0] WRITABLE_MASK               = 32'h387ec9ff;
    localparam logic [31:0] UNMAPPED_READ_VALUE         = 32'h00000000;

    // number of gated peripheral clocks
    localparam int unsigned GATE_COUNT = 21;

    // bit positions of the enables
    localparam int unsigned DAC_POS      = 29;
    localparam int unsigned POWER_POS    = 28;
    localparam int unsigned BACKUP_POS   = 27;
    localparam int unsigned I2C1_POS     = 22;
    localparam int unsigned I2C0_POS     = 21;
    localparam int unsigned UART4_POS    = 20;
    localparam int unsigned UART3_POS    = 19;
    localparam int unsigned USART2_POS   = 18;
    localparam int unsigned USART1_POS   = 17;
    localparam int unsigned SPI2_POS     = 15;
    localparam int unsigned SPI1_POS     = 14;
    localparam int unsigned WATCHDOG_POS = 11;
    localparam int unsigned TIMER13_POS  = 8;
    localparam int unsigned TIMER12_POS  = 7;
    localparam int unsigned TIMER11_POS  = 6;
    localparam int unsigned TIMER6_POS   = 5;
    localparam int unsigned TIMER1_POS   = 0;

    // gate index to register bit, index 0 is the dac gate
    localparam int unsigned GATE_POS [GATE_COUNT] = '{
        29, 28, 27, 22, 21, 20, 19, 18, 17, 15, 14, 11, 8, 7, 6, 5, 4, 3, 2, 1, 0
    };

    // cycles from a committed write to the gate outputs
    localparam int unsigned GATE_LATENCY = 2;

endpackage

// [hdl/apcg_wb_ack.sv]
// wishbone classic acknowledge generator, one wait state
`timescale 1ns/100ps
`default_nettype none
module apcg_wb_ack
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // bus request
    input  wire logic cyc,
    input  wire logic stb,
    // answer
    output logic      ack
);

    logic ackReg;
    logic ackNext;

    // ack drops the cycle after it was given, so one request never acks twice
    always_comb
    begin
        ackNext = cyc && stb && !ackReg;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ackReg <= 1'b0;
        end
        else
        begin
            ackReg <= ackNext;
        end
    end

    assign ack = ackReg;

endmodule
`default_nettype wire

// [hdl/apcg_gate_stage.sv]
// enable staging for one gated clock, output changes only while mclk is low
`timescale 1ns/100ps
`default_nettype none
module apcg_gate_stage
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // enable from the register
    input  wire logic enableIn,
    // enable toward the gating cell
    output logic      gateEnable
);

    logic stageReg;
    logic stageNext;
    logic lowReg;
    logic lowNext;

    always_comb
    begin
        stageNext = enableIn;
        lowNext   = stageReg;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            stageReg <= 1'b0;
        end
        else
        begin
            stageReg <= stageNext;
        end
    end

    // falling-edge capture keeps the and-type gate free of glitches
    always_ff @(negedge mclk)
    begin
        if (rst)
        begin
            lowReg <= 1'b0;
        end
        else
        begin
            lowReg <= lowNext;
        end
    end

    assign gateEnable = lowReg;

endmodule
`default_nettype wire

// [dv/test_apcg_top.sv]
// self-checking bench for the slow bus clock gate register block
`timescale 1ns/100ps
`default_nettype none
module test_apcg_top;
    logic        mclk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] datIn;
    logic [31:0] datOut;
    logic        ack;
    wire  [31:0] gateWord;
    int          errors;
    int          totalChecks;

    // gate index to register bit, index 0 is the dac gate
    int unsigned gatePos [21] = '{29, 28, 27, 22, 21, 20, 19, 18, 17, 15, 14,
                                  11, 8, 7, 6, 5, 4, 3, 2, 1, 0};

    // reserved positions carry no gate, tie them low for comparison
    assign gateWord[31:30] = 2'b00;
    assign gateWord[26:23] = 4'h0;
    assign gateWord[16]    = 1'b0;
    assign gateWord[13:12] = 2'b00;
    assign gateWord[10:9]  = 2'b00;

    apcg_top #(.ADDR_WIDTH(8)) dut
    (
        .mclk                    (mclk),
        .rst                     (rst),
        .wb_cyc_i                (cyc),
        .wb_stb_i                (stb),
        .wb_we_i                 (we),
        .wb_adr_i                (adr),
        .wb_sel_i                (sel),
        .wb_dat_i                (datIn),
        .wb_dat_o                (datOut),
        .wb_ack_o                (ack),
        .dacClockGate            (gateWord[29]),
        .powerUnitClockGate      (gateWord[28]),
        .backupIfClockGate       (gateWord[27]),
        .i2cPort1ClockGate       (gateWord[22]),
        .i2cPort0ClockGate       (gateWord[21]),
        .uartPort4ClockGate      (gateWord[20]),
        .uartPort3ClockGate      (gateWord[19]),
        .usartPort2ClockGate     (gateWord[18]),
        .usartPort1ClockGate     (gateWord[17]),
        .spiPort2ClockGate       (gateWord[15]),
        .spiPort1ClockGate       (gateWord[14]),
        .windowWatchdogClockGate (gateWord[11]),
        .timer13ClockGate        (gateWord[8]),
        .timer12ClockGate        (gateWord[7]),
        .timer11ClockGate        (gateWord[6]),
        .timer6ClockGate         (gateWord[5]),
        .timer5ClockGate         (gateWord[4]),
        .timer4ClockGate         (gateWord[3]),
        .timer3ClockGate         (gateWord[2]),
        .timer2ClockGate         (gateWord[1]),
        .timer1ClockGate         (gateWord[0])
    );

    always #2 mclk = ~mclk;

    task automatic conclude();
        $display("checks %0d errors %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        totalChecks++;
        if (seen !== expected)
        begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask

    // one classic cycle; request held until ack is sampled high
    task automatic wbCycle(input logic write, input logic [7:0] a, input logic [3:0] s,
                           input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge mclk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= write;
        adr   <= a;
        sel   <= s;
        datIn <= d;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = datOut;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (ack !== 1'b1)
        begin
            errors++;
            $display("Error at %0t: no bus acknowledge", $time);
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] q;
        wbCycle(1'b1, a, s, d, q);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] expected);
        logic [31:0] q;
        wbCycle(1'b0, a, 4'hf, 32'h00000000, q);
        check(q, expected);
    endtask

    // gates keep the old value one edge after commit, new value the edge after
    task automatic gateWrite(input logic [31:0] d, input logic [31:0] old,
                             input logic [31:0] expected);
        wr(8'h1c, 4'hf, d);
        @(posedge mclk);
        check(gateWord, old);
        @(posedge mclk);
        check(gateWord, expected);
    endtask

    initial
    begin
        logic [31:0] prev;
        logic [31:0] one;
        mclk        = 1'b0;
        rst         = 1'b1;
        cyc         = 1'b0;
        stb         = 1'b0;
        we          = 1'b0;
        adr         = 8'h00;
        sel         = 4'h0;
        datIn       = 32'h00000000;
        errors      = 0;
        totalChecks = 0;
        repeat (4) @(posedge mclk);
        check(gateWord, 32'h00000000);
        rst <= 1'b0;
        rdChk(8'h1c, 32'h00000000);
        $display("test reset value done");

        // walking one sets each enable and clears the previous one
        prev = 32'h00000000;
        for (int i = 0; i < 21; i++)
        begin
            one = 32'h00000001 << gatePos[i];
            gateWrite(one, prev, one);
            rdChk(8'h1c, one);
            rdChk(8'h3c, one);
            prev = one;
        end
        gateWrite(32'h00000000, prev, 32'h00000000);
        $display("test walking enables done");

        // reserved positions never take a one
        gateWrite(32'hffffffff, 32'h00000000, 32'h387ec9ff);
        rdChk(8'h1c, 32'h387ec9ff);
        gateWrite(32'h00000000, 32'h387ec9ff, 32'h00000000);
        $display("test reserved bits done");

        // byte lanes write only their own bits
        wr(8'h1c, 4'b0010, 32'h387ec9ff);
        rdChk(8'h1c, 32'h0000c900);
        wr(8'h1c, 4'b1100, 32'h387ec9ff);
        rdChk(8'h1c, 32'h387ec900);
        $display("test byte lanes done");

        // unmapped and read-only places leave the register alone
        wr(8'h20, 4'hf, 32'h00000000);
        wr(8'h3c, 4'hf, 32'h00000000);
        rdChk(8'h1c, 32'h387ec900);
        rdChk(8'h20, 32'h00000000);
        rdChk(8'h3c, 32'h387ec900);
        $display("test unmapped access done");

        // a reset in mid-run clears register and gates
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        check(gateWord, 32'h00000000);
        rdChk(8'h1c, 32'h00000000);
        $display("test mid-run reset done");
        conclude();
    end
endmodule
`default_nettype wire
